/* File: hw/obd_option_decode.sv */
module obd_option_decode #(
   parameter int PROG_CYCLES = obd_pkg::OBD_PROG_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output obd_pkg::obd_opts_t OPTS,
   output logic OPTS_VALID,
   output logic PROG_BUSY
);
   import obd_pkg::*;

   // ************************************************************
   // State.
   // ************************************************************
   logic aw_got_reg, aw_got_next;
   logic w_got_reg, w_got_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [2:0] pcr_reg, pcr_next;
   logic [0:0] paddr_reg, paddr_next;
   logic [7:0] pdata_reg, pdata_next;
   logic [31:0] tmr_reg, tmr_next;
   logic done_reg, done_next;
   logic capture_reg, capture_next;
   obd_opts_t opts_reg, opts_next;
   logic mem_wr;
   logic [15:0] store;
   logic wr_fire;
   logic data_hit;

   assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
   assign data_hit = wr_fire && (awaddr_reg == OBD_ADDR_DATA) && wstrb_reg[0];

   // Handshake readies are combinational; each channel is taken once per write.
   assign S_AXI_AWREADY = !aw_got_reg && !bvalid_reg;
   assign S_AXI_WREADY = !w_got_reg && !bvalid_reg;
   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;
   assign OPTS = opts_reg;
   assign OPTS_VALID = done_reg;
   assign PROG_BUSY = (tmr_reg != 32'h0);

   // The cell write happens when the power bit ends a timed pulse.
   obd_store_mem u_mem (
      .CORE_CLK(CORE_CLK),
      .RST_N(RST_N),
      .wr_en(mem_wr),
      .wr_idx(paddr_reg),
      .wr_data(pdata_reg),
      .rd_data(store)
   );

   // ************************************************************
   // Write channel, program control and programming timer.
   // ************************************************************
   always_comb begin
      aw_got_next = aw_got_reg;
      w_got_next = w_got_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      pcr_next = pcr_reg;
      paddr_next = paddr_reg;
      pdata_next = pdata_reg;
      tmr_next = tmr_reg;
      mem_wr = 1'b0;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_got_next = 1'b1;
         awaddr_next = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_got_next = 1'b1;
         wdata_next = S_AXI_WDATA;
         wstrb_next = S_AXI_WSTRB;
      end
      if (bvalid_reg && S_AXI_BREADY) begin
         bvalid_next = 1'b0;
      end
      // Programming pulse counts down to zero once started, even if power drops.
      if (tmr_reg != 32'h0) begin
         tmr_next = tmr_reg - 32'h1;
      end
      if (wr_fire) begin
         aw_got_next = 1'b0;
         w_got_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = OBD_RESP_OKAY;
         unique case (awaddr_reg)
            OBD_ADDR_PCR: begin
               if (wstrb_reg[0]) begin
                  // Enable bit only changes while the latch is off, so a store write in flight keeps its gate.
                  if (!pcr_reg[OBD_PCR_LATCH_BIT]) begin
                     pcr_next[OBD_PCR_ENABLE_BIT] = wdata_reg[OBD_PCR_ENABLE_BIT];
                  end
                  pcr_next[OBD_PCR_LATCH_BIT] = wdata_reg[OBD_PCR_LATCH_BIT];
                  // Power can only be on with the latch set.
                  pcr_next[OBD_PCR_PGM_BIT] = wdata_reg[OBD_PCR_PGM_BIT] && wdata_reg[OBD_PCR_LATCH_BIT]
                                              && pcr_reg[OBD_PCR_LATCH_BIT];
                  if (pcr_next[OBD_PCR_PGM_BIT] && !pcr_reg[OBD_PCR_PGM_BIT]) begin
                     tmr_next = 32'(PROG_CYCLES);
                  end
                  // Power dropping after a full pulse commits the byte, if enabled.
                  if (pcr_reg[OBD_PCR_PGM_BIT] && !pcr_next[OBD_PCR_PGM_BIT] && tmr_reg == 32'h0
                      && pcr_reg[OBD_PCR_ENABLE_BIT]) begin
                     mem_wr = 1'b1;
                  end
               end
            end
            OBD_ADDR_ADDR: begin
               if (wstrb_reg[0] && pcr_reg[OBD_PCR_LATCH_BIT]) begin
                  paddr_next = wdata_reg[0:0];
               end
            end
            OBD_ADDR_DATA: begin
               if (wstrb_reg[0] && pcr_reg[OBD_PCR_LATCH_BIT]) begin
                  pdata_next = wdata_reg[7:0];
               end
            end
            OBD_ADDR_STORE, OBD_ADDR_DECODED, OBD_ADDR_STATUS: begin
               bresp_next = OBD_RESP_OKAY;
            end
            default: begin
               bresp_next = OBD_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= OBD_RESP_OKAY;
         pcr_reg <= OBD_PCR_RESET;
         paddr_reg <= OBD_STORE_BYTE0;
         pdata_reg <= 8'h00;
         tmr_reg <= 32'h0;
      end else begin
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         pcr_reg <= pcr_next;
         paddr_reg <= paddr_next;
         pdata_reg <= pdata_next;
         tmr_reg <= tmr_next;
      end
   end

   // ************************************************************
   // Read channel.
   // ************************************************************
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_next = 1'b0;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_next = 1'b1;
         rresp_next = OBD_RESP_OKAY;
         rdata_next = 32'h0;
         unique case (S_AXI_ARADDR)
            OBD_ADDR_PCR: rdata_next = {29'h0, pcr_reg};
            OBD_ADDR_ADDR: rdata_next = {31'h0, paddr_reg};
            OBD_ADDR_DATA: rdata_next = {24'h0, pdata_reg};
            // Reading the store while latched is not meaningful; it reads zero then.
            OBD_ADDR_STORE: rdata_next = pcr_reg[OBD_PCR_LATCH_BIT] ? 32'h0 : {16'h0, store};
            OBD_ADDR_DECODED: rdata_next = {14'h0, opts_reg};
            OBD_ADDR_STATUS: rdata_next = {30'h0, PROG_BUSY, done_reg};
            default: rresp_next = OBD_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= OBD_RESP_OKAY;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // ************************************************************
   // Option capture after reset release.
   // ************************************************************
   // The store's registered read port is valid one edge after release, so the
   // capture waits one cycle; the options are then frozen until next reset.
   always_comb begin
      capture_next = 1'b1;
      done_next = done_reg || capture_reg;
      opts_next = opts_reg;
      if (capture_reg && !done_reg) begin
         opts_next.stop_enable = store[OBD_OPT_STOP_BIT];
         opts_next.edge_only = store[OBD_OPT_TRIG_BIT];
         opts_next.pulls_on = store[OBD_OPT_PULL_BIT];
         opts_next.port_irq_enable = !store[OBD_OPT_PINT_BIT];
         opts_next.startup_cycles = store[OBD_OPT_DLY_BIT] ? OBD_DELAY_SHORT : OBD_DELAY_LONG;
         opts_next.lvr_enable = store[OBD_OPT_LVR_BIT];
         opts_next.watchdog_enable = !store[OBD_OPT_WDOG_BIT];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         capture_reg <= 1'b0;
         done_reg <= 1'b0;
         opts_reg <= '0;
      end else begin
         capture_reg <= capture_next;
         done_reg <= done_next;
         opts_reg <= opts_next;
      end
   end

   // ************************************************************
   // Checks.
   // ************************************************************
   property p_wdog_inv;
      @(posedge CORE_CLK) disable iff (!RST_N)
         $rose(done_reg) |-> opts_reg.watchdog_enable == !$past(store[OBD_OPT_WDOG_BIT]);
   endproperty
   a_wdog_inv: assert property (p_wdog_inv) else $error("watchdog polarity wrong");

   property p_delay;
      @(posedge CORE_CLK) disable iff (!RST_N)
         $rose(done_reg) |-> opts_reg.startup_cycles == ($past(store[OBD_OPT_DLY_BIT]) ? 12'h0E0 : 12'hFE0);
   endproperty
   a_delay: assert property (p_delay) else $error("startup count wrong");

   property p_hold;
      @(posedge CORE_CLK) disable iff (!RST_N)
         done_reg |=> $stable(opts_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("options changed after capture");

   property p_pint;
      @(posedge CORE_CLK) disable iff (!RST_N)
         $rose(done_reg) |-> opts_reg.port_irq_enable == !$past(store[OBD_OPT_PINT_BIT]);
   endproperty
   a_pint: assert property (p_pint) else $error("port interrupt polarity wrong");

   property p_stop;
      @(posedge CORE_CLK) disable iff (!RST_N)
         $rose(done_reg) |-> opts_reg.stop_enable == $past(store[OBD_OPT_STOP_BIT])
            && opts_reg.edge_only == $past(store[OBD_OPT_TRIG_BIT]);
   endproperty
   a_stop: assert property (p_stop) else $error("stop or trigger option wrong");

   property p_pulls;
      @(posedge CORE_CLK) disable iff (!RST_N)
         $rose(done_reg) |-> opts_reg.pulls_on == $past(store[OBD_OPT_PULL_BIT])
            && opts_reg.lvr_enable == $past(store[OBD_OPT_LVR_BIT]);
   endproperty
   a_pulls: assert property (p_pulls) else $error("pull or lvr option wrong");

   property p_gate;
      @(posedge CORE_CLK) disable iff (!RST_N)
         mem_wr |-> pcr_reg[OBD_PCR_ENABLE_BIT];
   endproperty
   a_gate: assert property (p_gate) else $error("store written without enable");

   property p_pgm_latch;
      @(posedge CORE_CLK) disable iff (!RST_N)
         pcr_reg[OBD_PCR_PGM_BIT] |-> pcr_reg[OBD_PCR_LATCH_BIT];
   endproperty
   a_pgm_latch: assert property (p_pgm_latch) else $error("power on without latch");

   sequence s_capture;
      !done_reg ##1 done_reg;
   endsequence
   property p_capture_time;
      @(posedge CORE_CLK) disable iff (!RST_N)
         $rose(capture_reg) |-> s_capture;
   endproperty
   a_capture_time: assert property (p_capture_time) else $error("capture not one cycle after release");
endmodule

/* File: include/obd_pkg.sv */
package obd_pkg;

   // ************************************************************
   // Register map (byte addresses on the AXI4-Lite bus).
   // ************************************************************
   localparam logic [7:0] OBD_ADDR_PCR = 8'h00;
   localparam logic [7:0] OBD_ADDR_ADDR = 8'h04;
   localparam logic [7:0] OBD_ADDR_DATA = 8'h08;
   localparam logic [7:0] OBD_ADDR_STORE = 8'h0C;
   localparam logic [7:0] OBD_ADDR_DECODED = 8'h10;
   localparam logic [7:0] OBD_ADDR_STATUS = 8'h14;

   // ************************************************************
   // Program control register fields.
   // ************************************************************
   localparam int OBD_PCR_PGM_BIT = 0;
   localparam int OBD_PCR_LATCH_BIT = 1;
   localparam int OBD_PCR_ENABLE_BIT = 2;
   localparam logic [2:0] OBD_PCR_RESET = 3'h0;

   // Option store byte indices.
   localparam logic [0:0] OBD_STORE_BYTE0 = 1'h0;
   localparam logic [0:0] OBD_STORE_BYTE1 = 1'h1;
   localparam logic [15:0] OBD_STORE_RESET = 16'h0000;

   // ************************************************************
   // Option bit positions, all within store byte 0.
   // ************************************************************
   localparam int OBD_OPT_STOP_BIT = 0;
   localparam int OBD_OPT_TRIG_BIT = 1;
   localparam int OBD_OPT_PULL_BIT = 2;
   localparam int OBD_OPT_PINT_BIT = 3;
   localparam int OBD_OPT_DLY_BIT = 4;
   localparam int OBD_OPT_LVR_BIT = 5;
   localparam int OBD_OPT_WDOG_BIT = 6;

   // ************************************************************
   // Start-up delay counts in internal clock cycles.
   // ************************************************************
   localparam logic [11:0] OBD_DELAY_SHORT = 12'h0E0;
   localparam logic [11:0] OBD_DELAY_LONG = 12'hFE0;

   // Byte write time of the store, in microseconds, and its cycle count.
   localparam int OBD_CLK_MHZ = 100;
   localparam int OBD_PROG_TIME_US = 1000;
   localparam int OBD_PROG_CYCLES = OBD_PROG_TIME_US * OBD_CLK_MHZ;

   // AXI response codes.
   localparam logic [1:0] OBD_RESP_OKAY = 2'h0;
   localparam logic [1:0] OBD_RESP_SLVERR = 2'h2;

   // Decoded options as one carrier.
   typedef struct packed {
      logic stop_enable;
      logic edge_only;
      logic pulls_on;
      logic port_irq_enable;
      logic lvr_enable;
      logic watchdog_enable;
      logic [11:0] startup_cycles;
   } obd_opts_t;

endpackage

/* File: hw/obd_store_mem.sv */
// Two-byte nonvolatile option store; read data comes from a register.
// The cells carry no reset, so programmed options survive a device reset and
// are decoded again at the next release. A write replaces the whole byte,
// which is simpler than modelling cells that can only move one way.
module obd_store_mem (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic wr_en,
   input wire logic [0:0] wr_idx,
   input wire logic [7:0] wr_data,
   output logic [15:0] rd_data
);
   import obd_pkg::*;

   // Cells start blank at power-up and are never touched by reset.
   logic [15:0] cells_reg = OBD_STORE_RESET;
   logic [15:0] cells_next;

   // ************************************************************
   // Cell update.
   // ************************************************************
   always_comb begin
      cells_next = cells_reg;
      if (wr_en) begin
         if (wr_idx == OBD_STORE_BYTE0) begin
            cells_next[7:0] = wr_data;
         end else begin
            cells_next[15:8] = wr_data;
         end
      end
   end

   // Cells keep their contents through reset, as a nonvolatile array must.
   always_ff @(posedge CORE_CLK) begin
      cells_reg <= cells_next;
   end

   // Registered read port; it shows the cells again one edge after release.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_data <= OBD_STORE_RESET;
      end else begin
         rd_data <= cells_next;
      end
   end
endmodule

/* File: tb/obd_tb.sv */
module tb import obd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Stimulus signals and the unit under test.
   // ************************************************************
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0000_0000;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   obd_opts_t opts;
   obd_opts_t dflt;
   logic opts_valid;
   logic prog_busy;
   int err_total = 0;
   int num_checks = 0;
   int cycles = 0;

   // The programming timer is shortened so each byte write takes a handful of cycles.
   obd_option_decode #(.PROG_CYCLES(5)) obd_option_decode_i (
      .CORE_CLK(core_clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .OPTS(opts), .OPTS_VALID(opts_valid), .PROG_BUSY(prog_busy)
   );

   // Free-running 100 MHz clock.
   always #5 core_clk = ~core_clk;

   // A hung handshake would stall the run forever, so a cycle ceiling cuts it short.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         final_report();
      end
   end

   // ************************************************************
   // Comparison, bus and reporting helpers.
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("Checks made %0d, mismatches %0d.", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Readiness is sampled at the falling edge, where no input is changing, so the
   // following rising edge is known to complete the transfer.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] r;
      b = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(negedge core_clk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid & bready;
         r = bresp;
         @(posedge core_clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
      end
      chk(32'(r), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ar, rv;
      logic [31:0] d;
      logic [1:0] r;
      rv = 1'b0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rv) begin
         @(negedge core_clk);
         ar = arvalid & arready;
         rv = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge core_clk);
         if (ar) arvalid <= 1'b0;
         if (rv) rready <= 1'b0;
      end
      chk(d, ed);
      chk(32'(r), 32'(er));
   endtask

   // Reset is held three cycles; the options load on the second edge after release.
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(32'(opts_valid), 32'h0);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask

   // One full store write; early drops programming power before the timer ends.
   task automatic prog(input logic [31:0] en, input logic [7:0] idx, input logic [7:0] val, input logic early);
      wr(OBD_ADDR_PCR, en | 32'h2, OBD_RESP_OKAY);
      rd(OBD_ADDR_PCR, en | 32'h2, OBD_RESP_OKAY);
      wr(OBD_ADDR_ADDR, 32'(idx), OBD_RESP_OKAY);
      wr(OBD_ADDR_DATA, 32'(val), OBD_RESP_OKAY);
      rd(OBD_ADDR_STORE, 32'h0000_0000, OBD_RESP_OKAY);
      wr(OBD_ADDR_PCR, en | 32'h3, OBD_RESP_OKAY);
      chk(32'(prog_busy), 32'h1);
      if (!early) while (prog_busy) @(negedge core_clk);
      wr(OBD_ADDR_PCR, en | 32'h2, OBD_RESP_OKAY);
      wr(OBD_ADDR_PCR, en, OBD_RESP_OKAY);
   endtask

   // ************************************************************
   // Scenarios.
   // ************************************************************
   task automatic t_reset_state();
      chk(32'(opts_valid), 32'h1);
      chk(32'(opts.stop_enable), 32'h0);
      chk(32'(opts.edge_only), 32'h0);
      chk(32'(opts.pulls_on), 32'h0);
      chk(32'(opts.port_irq_enable), 32'h1);
      chk(32'(opts.startup_cycles), 32'h0000_0FE0);
      chk(32'(opts.lvr_enable), 32'h0);
      chk(32'(opts.watchdog_enable), 32'h1);
      rd(OBD_ADDR_DECODED, 32'(dflt), OBD_RESP_OKAY);
      rd(OBD_ADDR_STATUS, 32'h0000_0001, OBD_RESP_OKAY);
      rd(OBD_ADDR_PCR, 32'h0000_0000, OBD_RESP_OKAY);
      rd(OBD_ADDR_STORE, 32'(OBD_STORE_RESET), OBD_RESP_OKAY);
   endtask

   // Both bytes are written back to back; decoded options must not move before a reset.
   task automatic t_program();
      prog(32'h4, 8'h00, 8'h7F, 1'b0);
      prog(32'h4, 8'h01, 8'hA5, 1'b0);
      rd(OBD_ADDR_STORE, 32'h0000_A57F, OBD_RESP_OKAY);
      chk(32'(opts), 32'(dflt));
      rd(OBD_ADDR_STATUS, 32'h0000_0001, OBD_RESP_OKAY);
   endtask

   // Writes with the enable clear, or with power cut short, must leave the store alone.
   task automatic t_blocked();
      wr(OBD_ADDR_PCR, 32'h0, OBD_RESP_OKAY);
      prog(32'h0, 8'h00, 8'hFF, 1'b0);
      rd(OBD_ADDR_STORE, 32'h0000_A57F, OBD_RESP_OKAY);
      prog(32'h4, 8'h01, 8'h00, 1'b1);
      rd(OBD_ADDR_STORE, 32'h0000_A57F, OBD_RESP_OKAY);
      wr(OBD_ADDR_PCR, 32'h5, OBD_RESP_OKAY);
      rd(OBD_ADDR_PCR, 32'h0000_0004, OBD_RESP_OKAY);
   endtask

   // Unmapped places answer with an error; read-only places ignore writes.
   task automatic t_refuse();
      wr(8'h18, 32'hFFFF_FFFF, OBD_RESP_SLVERR);
      rd(8'h18, 32'h0000_0000, OBD_RESP_SLVERR);
      wr(OBD_ADDR_STORE, 32'h0000_FFFF, OBD_RESP_OKAY);
      rd(OBD_ADDR_STORE, 32'h0000_A57F, OBD_RESP_OKAY);
      wr(OBD_ADDR_DECODED, 32'hFFFF_FFFF, OBD_RESP_OKAY);
      rd(OBD_ADDR_DECODED, 32'(dflt), OBD_RESP_OKAY);
   endtask

   // The store keeps byte 0 = 7F through reset, so every option flips from its blank value.
   task automatic t_reload();
      chk(32'(opts_valid), 32'h1);
      chk(32'(opts.stop_enable), 32'h1);
      chk(32'(opts.edge_only), 32'h1);
      chk(32'(opts.pulls_on), 32'h1);
      chk(32'(opts.port_irq_enable), 32'h0);
      chk(32'(opts.startup_cycles), 32'h0000_00E0);
      chk(32'(opts.lvr_enable), 32'h1);
      chk(32'(opts.watchdog_enable), 32'h0);
      rd(OBD_ADDR_DECODED, 32'h0003_A0E0, OBD_RESP_OKAY);
      rd(OBD_ADDR_STATUS, 32'h0000_0001, OBD_RESP_OKAY);
      rd(OBD_ADDR_PCR, 32'h0000_0000, OBD_RESP_OKAY);
      rd(OBD_ADDR_STORE, 32'h0000_A57F, OBD_RESP_OKAY);
   endtask

   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      dflt = '0;
      dflt.port_irq_enable = 1'b1;
      dflt.watchdog_enable = 1'b1;
      dflt.startup_cycles = OBD_DELAY_LONG;
      do_reset();
      t_reset_state();
      t_program();
      t_blocked();
      t_refuse();
      do_reset();
      t_reload();
      final_report();
   end
endmodule
